// File: hdl/dir_top.sv
// identity register bank with AXI4-Lite slave port
// assumes a single 100 MHz clock and an AXI4-Lite master obeying the protocol
//
// Design decision made here: the AXI4-Lite interface to the registers.
`default_nettype none
module dir_top #(
  parameter logic [2:0]  MEM_TYPE  = dir_pkg::DIR_MT_ROM_FLASH,
  parameter logic [7:0]  PSET_CODE = 8'h5A, // arbitrary value
  parameter logic [3:0]  SRAM_CODE = 4'h9,
  parameter logic [3:0]  SIZE2     = 4'h7,
  parameter logic [3:0]  SIZE1     = 4'h3,
  parameter logic [2:0]  PROC_KIND = 3'h1, // arbitrary value
  parameter logic [4:0]  REVISION  = 5'h01, // arbitrary value
  parameter logic        EXT_FLAG  = 1'b1,
  parameter logic        HAS_DISP  = 1'b1,
  parameter logic        HOST_ROLE = 1'b1,
  parameter logic        HAS_USB   = 1'b1,
  parameter logic        HAS_AES   = 1'b1
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST,
  input  wire logic [31:0] I_AWADDR,
  input  wire logic        I_AWVALID,
  output var  logic        O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output var  logic        O_WREADY,
  output var  logic [1:0]  O_BRESP,
  output var  logic        O_BVALID,
  input  wire logic        I_BREADY,
  input  wire logic [31:0] I_ARADDR,
  input  wire logic        I_ARVALID,
  output var  logic        O_ARREADY,
  output var  logic [31:0] O_RDATA,
  output var  logic [1:0]  O_RRESP,
  output var  logic        O_RVALID,
  input  wire logic        I_RREADY
);
  import dir_pkg::*;

  localparam logic [31:0] EXT_VAL =
    (32'(HAS_DISP) << DIR_POS_DISP) | (32'(HOST_ROLE) << DIR_POS_HOSTR) |
    (32'(HAS_USB) << DIR_POS_USB) | (32'(HAS_AES) << DIR_POS_AES);

  dir_rd_if rd ();

  // all fields fixed at build time, no software path to them
  dir_words #(
    .XFLAG   (EXT_FLAG),
    .MTYPE   (MEM_TYPE),
    .PSET    (PSET_CODE),
    .SRAMC   (SRAM_CODE),
    .SIZ2    (SIZE2),
    .SIZ     (SIZE1),
    .PROC    (PROC_KIND),
    .REV     (REVISION),
    .EXT_VAL (EXT_VAL)
  ) u_words (
    .rd (rd.rsp)
  );

  // write path: address and data taken in either order, then one response
  logic aw_held;
  logic w_held;
  logic aw_fire;
  logic w_fire;
  assign aw_fire = I_AWVALID & O_AWREADY;
  assign w_fire  = I_WVALID & O_WREADY;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      O_AWREADY <= 1'b0;
      O_WREADY  <= 1'b0;
    end else begin
      O_AWREADY <= ~aw_held & ~aw_fire & ~O_BVALID & ~O_AWREADY;
      O_WREADY  <= ~w_held & ~w_fire & ~O_WREADY & ~O_BVALID;
      if (O_BVALID & I_BREADY) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end else begin
        if (aw_fire) aw_held <= 1'b1;
        if (w_fire) w_held <= 1'b1;
      end
    end
  end

  // write data is discarded, every write answers okay
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_BVALID <= 1'b0;
      O_BRESP  <= DIR_RESP_OKAY;
    end else if (O_BVALID) begin
      if (I_BREADY) O_BVALID <= 1'b0;
    end else if ((aw_held | aw_fire) & (w_held | w_fire)) begin
      O_BVALID <= 1'b1;
      O_BRESP  <= DIR_RESP_OKAY;
    end
  end

  // read path: one read at a time, data registered
  assign rd.addr = I_ARADDR;

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_ARREADY <= 1'b0;
    end else begin
      O_ARREADY <= ~O_ARREADY & ~O_RVALID & I_ARVALID;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      O_RVALID <= 1'b0;
      O_RDATA  <= DIR_ZERO;
      O_RRESP  <= DIR_RESP_OKAY;
    end else if (I_ARVALID & O_ARREADY) begin
      O_RVALID <= 1'b1;
      O_RDATA  <= rd.data;
      O_RRESP  <= rd.hit ? DIR_RESP_OKAY : DIR_RESP_DECERR;
    end else if (O_RVALID & I_RREADY) begin
      O_RVALID <= 1'b0;
    end
  end

  // checks
  chk_ext_zero_read: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_ARVALID && O_ARREADY && I_ARADDR == DIR_OFS_EXT && !EXT_FLAG)
      |=> (O_RVALID && O_RDATA == DIR_ZERO))
    else $error("extension word not zero with flag clear");
  chk_main_flag_bit: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_ARVALID && O_ARREADY && I_ARADDR == DIR_OFS_MAIN)
      |=> (O_RDATA[DIR_POS_XFLAG] == EXT_FLAG))
    else $error("extension flag wrong in main word");
  chk_main_fields: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_ARVALID && O_ARREADY && I_ARADDR == DIR_OFS_MAIN)
      |=> (O_RDATA[30:28] == MEM_TYPE && O_RDATA[27:20] == PSET_CODE
           && O_RDATA[19:16] == SRAM_CODE && O_RDATA[4:0] == REVISION))
    else $error("main word field layout wrong");
  chk_main_sizes: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_ARVALID && O_ARREADY && I_ARADDR == DIR_OFS_MAIN)
      |=> (O_RDATA[15:12] == SIZE2 && O_RDATA[11:8] == SIZE1
           && O_RDATA[7:5] == PROC_KIND))
    else $error("size or processor fields wrong");
  chk_ext_bits: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_ARVALID && O_ARREADY && I_ARADDR == DIR_OFS_EXT && EXT_FLAG)
      |=> (O_RDATA[3:0] == {HAS_DISP, HOST_ROLE, HAS_USB, HAS_AES}))
    else $error("extension option bits wrong");
  chk_read_answer: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (I_ARVALID && O_ARREADY && (I_ARADDR == DIR_OFS_MAIN || I_ARADDR == DIR_OFS_EXT))
      |=> (O_RVALID && O_RRESP == DIR_RESP_OKAY))
    else $error("mapped read not answered okay");
  chk_write_okay: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_BVALID |-> O_BRESP == DIR_RESP_OKAY)
    else $error("write answered with error");
  chk_data_stable: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && !I_RREADY) |=> (O_RVALID && $stable(O_RDATA)))
    else $error("read data changed while waiting");
  chk_write_resp: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (aw_fire && w_fire) |=> O_BVALID)
    else $error("write response missing");

  // checker helpers, decoded the way the bus decode sees the address
  function automatic logic addr_is(
    input logic [31:0] addr,
    input logic [31:0] ofs
  );
    return addr[31:2] == ofs[31:2];
  endfunction : addr_is

  logic        ar_take;
  logic        rd_was_main;
  logic        rd_was_ext;
  logic        rd_was_hit;
  logic        main_seen_ok;
  logic [31:0] main_seen;
  logic        ext_seen_ok;
  logic [31:0] ext_seen;
  assign ar_take = I_ARVALID & O_ARREADY;

  // word named by the read in flight, steady while the answer stands
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      rd_was_main <= 1'b0;
      rd_was_ext  <= 1'b0;
      rd_was_hit  <= 1'b0;
    end else if (ar_take) begin
      rd_was_main <= addr_is(I_ARADDR, DIR_OFS_MAIN);
      rd_was_ext  <= addr_is(I_ARADDR, DIR_OFS_EXT);
      rd_was_hit  <= addr_is(I_ARADDR, DIR_OFS_MAIN) | addr_is(I_ARADDR, DIR_OFS_EXT);
    end
  end

  // first answer of each word is the reference for every later read
  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      main_seen_ok <= 1'b0;
      main_seen    <= DIR_ZERO;
    end else if (O_RVALID & I_RREADY & rd_was_main & ~main_seen_ok) begin
      main_seen_ok <= 1'b1;
      main_seen    <= O_RDATA;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RST) begin
    if (I_RST) begin
      ext_seen_ok <= 1'b0;
      ext_seen    <= DIR_ZERO;
    end else if (O_RVALID & I_RREADY & rd_was_ext & ~ext_seen_ok) begin
      ext_seen_ok <= 1'b1;
      ext_seen    <= O_RDATA;
    end
  end

  // contents of every answered read, by word; writes in between must not show
  chk_main_repeat: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_main && main_seen_ok)
      |-> (O_RDATA == main_seen))
    else $error("main word moved between reads");

  chk_ext_repeat: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_ext && ext_seen_ok)
      |-> (O_RDATA == ext_seen))
    else $error("extension word moved between reads");

  chk_flag_in_main: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_main)
      |-> (O_RDATA[DIR_POS_XFLAG] == EXT_FLAG))
    else $error("extension flag bit wrong");

  chk_ext_clear: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_ext && !EXT_FLAG)
      |-> (O_RDATA == DIR_ZERO))
    else $error("extension word not zero with flag clear");

  chk_ext_options: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_ext && EXT_FLAG)
      |-> (O_RDATA == {28'h0, HAS_DISP, HOST_ROLE, HAS_USB, HAS_AES}))
    else $error("extension option word wrong");

  chk_ext_unused: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_ext)
      |-> (O_RDATA[31:4] == 28'h0))
    else $error("unused extension bits set");

  chk_host_role: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_ext && EXT_FLAG)
      |-> (O_RDATA[DIR_POS_HOSTR] == HOST_ROLE))
    else $error("host role bit wrong");

  chk_mtype_code: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_main)
      |-> (O_RDATA[30:28] == MEM_TYPE && O_RDATA[30:28] <= DIR_MT_SRAM))
    else $error("memory type code wrong");

  chk_rom_flash_sizes: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_main && MEM_TYPE == DIR_MT_ROM_FLASH)
      |-> (O_RDATA[11:8] == SIZE1 && O_RDATA[15:12] == SIZE2))
    else $error("rom and flash sizes wrong");

  chk_pset_code: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_main)
      |-> (O_RDATA[27:20] == PSET_CODE))
    else $error("peripheral set code wrong");

  chk_sram_code: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_main)
      |-> (O_RDATA[19:16] == SRAM_CODE))
    else $error("sram size code wrong");

  chk_proc_code: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_main)
      |-> (O_RDATA[7:5] == PROC_KIND))
    else $error("processor kind code wrong");

  chk_rev_code: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_main)
      |-> (O_RDATA[4:0] == REVISION))
    else $error("revision code wrong");

  chk_unmapped_read: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && !rd_was_hit)
      |-> (O_RRESP == DIR_RESP_DECERR && O_RDATA == DIR_ZERO))
    else $error("unmapped read not refused");

  chk_mapped_okay: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && rd_was_hit)
      |-> (O_RRESP == DIR_RESP_OKAY))
    else $error("mapped read refused");

  chk_read_latency: assert property (@(posedge I_MCLK) disable iff (I_RST)
    ar_take
      |=> O_RVALID)
    else $error("read answer late");

  // handshake shape: one-cycle readies, one transfer of each kind at a time
  chk_aw_pulse: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_AWREADY
      |=> !O_AWREADY)
    else $error("address ready longer than one cycle");
  chk_w_pulse: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_WREADY
      |=> !O_WREADY)
    else $error("data ready longer than one cycle");
  chk_ar_pulse: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_ARREADY
      |=> !O_ARREADY)
    else $error("read ready longer than one cycle");
  chk_ar_after_valid: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_ARREADY
      |-> $past(I_ARVALID))
    else $error("read ready without a request");
  chk_one_read: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_RVALID
      |-> !O_ARREADY)
    else $error("second read taken while answering");
  chk_one_write: assert property (@(posedge I_MCLK) disable iff (I_RST)
    O_BVALID
      |-> (!O_AWREADY && !O_WREADY))
    else $error("second write taken while answering");
  chk_both_held: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (aw_held && w_held)
      |-> O_BVALID)
    else $error("complete write left unanswered");
  chk_held_clear: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_BVALID && I_BREADY)
      |=> (!aw_held && !w_held))
    else $error("write halves kept after response");
  chk_bvalid_drop: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_BVALID && I_BREADY)
      |=> !O_BVALID)
    else $error("write response repeated");
  chk_rvalid_drop: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && I_RREADY)
      |=> !O_RVALID)
    else $error("read answer repeated");
  chk_rresp_stable: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (O_RVALID && !I_RREADY)
      |=> $stable(O_RRESP))
    else $error("read response changed while waiting");
endmodule : dir_top
`default_nettype wire

// File: hdl/dir_pkg.sv
// constants, offsets and field layout of the identity register bank
// assumes a 32-bit AXI4-Lite register port
`default_nettype none
package dir_pkg;
  localparam logic [31:0] DIR_OFS_MAIN  = 32'h0000_0000;
  localparam logic [31:0] DIR_OFS_EXT   = 32'h0000_0004;
  localparam int          DIR_ADDR_W    = 32;
  localparam int          DIR_DATA_W    = 32;
  // main word field positions (lsb)
  localparam int          DIR_POS_XFLAG = 31;
  localparam int          DIR_POS_MTYP  = 28;
  localparam int          DIR_POS_PSET  = 20;
  localparam int          DIR_POS_SRAM  = 16;
  localparam int          DIR_POS_SIZ2  = 12;
  localparam int          DIR_POS_SIZ   = 8;
  localparam int          DIR_POS_PROC  = 5;
  localparam int          DIR_POS_REV   = 0;
  // extension word bit positions
  localparam int          DIR_POS_DISP  = 3;
  localparam int          DIR_POS_HOSTR = 2;
  localparam int          DIR_POS_USB   = 1;
  localparam int          DIR_POS_AES   = 0;
  // program memory type codes
  localparam logic [2:0]  DIR_MT_ROM       = 3'h0;
  localparam logic [2:0]  DIR_MT_ROMLESS   = 3'h1;
  localparam logic [2:0]  DIR_MT_FLASH     = 3'h2;
  localparam logic [2:0]  DIR_MT_ROM_FLASH = 3'h3;
  localparam logic [2:0]  DIR_MT_SRAM      = 3'h4;
  localparam logic [1:0]  DIR_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  DIR_RESP_DECERR  = 2'h3;
  localparam logic [31:0] DIR_ZERO         = 32'h0000_0000;
endpackage : dir_pkg
`default_nettype wire

// File: hdl/dir_rd_if.sv
// read lookup channel between the bus slave and the identity word source
// assumes one clock domain
`default_nettype none
interface dir_rd_if;
  logic [31:0] addr;
  logic [31:0] data;
  logic        hit;
  modport req (output addr, input data, input hit);
  modport rsp (input addr, output data, output hit);
endinterface : dir_rd_if
`default_nettype wire

// File: hdl/dir_words.sv
// hard-wired identity word source, combinational lookup
// assumes fields are set once by parameters at build time
`default_nettype none
module dir_words #(
  parameter logic        XFLAG   = 1'b1,
  parameter logic [2:0]  MTYPE   = 3'h2,
  parameter logic [7:0]  PSET    = 8'h5A,
  parameter logic [3:0]  SRAMC   = 4'h1,
  parameter logic [3:0]  SIZ2    = 4'h0,
  parameter logic [3:0]  SIZ     = 4'h1,
  parameter logic [2:0]  PROC    = 3'h1,
  parameter logic [4:0]  REV     = 5'h01,
  parameter logic [31:0] EXT_VAL = 32'h0000_0001
) (
  dir_rd_if.rsp rd
);
  import dir_pkg::*;
  logic [31:0] main_identity_word;
  logic [31:0] extension_identity_word;

  // layout of the main word
  assign main_identity_word = {XFLAG, MTYPE, PSET, SRAMC, SIZ2, SIZ, PROC, REV};
  // extension reads zero unless announced
  assign extension_identity_word = XFLAG ? EXT_VAL : DIR_ZERO;

  always_comb begin
    rd.hit  = 1'b1;
    rd.data = DIR_ZERO;
    unique case ({rd.addr[31:2], 2'b00})
      DIR_OFS_MAIN: rd.data = main_identity_word;
      DIR_OFS_EXT:  rd.data = extension_identity_word;
      default:      rd.hit  = 1'b0;
    endcase
  end
endmodule : dir_words
`default_nettype wire

// File: dv/dir_top_tb.sv
// self-checking bench for the identity register bank
// assumes dir_pkg and dir_top compiled first; two builds, extension flag set and clear
`default_nettype none
module dir_top_tb;
  import dir_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] PS = 8'hC3;
  localparam logic [3:0] SR = 4'hA;
  localparam logic [3:0] S2 = 4'h9;
  localparam logic [3:0] S1 = 4'h5;
  localparam logic [2:0] PK = 3'h6;
  localparam logic [4:0] RV = 5'h13;
  localparam logic [31:0] M1 = {1'b1, DIR_MT_ROM_FLASH, PS, SR, S2, S1, PK, RV};
  localparam logic [31:0] M2 = {1'b0, DIR_MT_SRAM, PS, SR, S2, S1, PK, RV};
  localparam logic [31:0] X1 = {28'h0, 4'hA};
  logic        clk = 1'b0, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata, rdata2, d, d2;
  logic        awready, wready, bvalid, arready, rvalid, rvalid2, bvalid2, v2;
  logic [1:0]  bresp, rresp, r, bresp2, rresp2, r2;
  logic [3:0]  wstrb;
  int          fail_count = 0;
  int          checks = 0;
  logic [31:0] adr [6] = '{32'h0, 32'h4, 32'h6, 32'h8, 32'h0, 32'h4};
  logic [31:0] e1 [6] = '{M1, X1, X1, 32'h0, M1, X1};
  logic [31:0] e2 [6] = '{M2, 32'h0, 32'h0, 32'h0, M2, 32'h0};
  always #5 clk = ~clk;
  dir_top #(.MEM_TYPE(DIR_MT_ROM_FLASH), .PSET_CODE(PS), .SRAM_CODE(SR), .SIZE2(S2),
    .SIZE1(S1), .PROC_KIND(PK), .REVISION(RV), .EXT_FLAG(1'b1), .HAS_DISP(1'b1),
    .HOST_ROLE(1'b0), .HAS_USB(1'b1), .HAS_AES(1'b0)) i_dut (
    .I_MCLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready));
  // clear flag: same inputs, so its answers land on the same edges as the first build
  dir_top #(.MEM_TYPE(DIR_MT_SRAM), .PSET_CODE(PS), .SRAM_CODE(SR), .SIZE2(S2),
    .SIZE1(S1), .PROC_KIND(PK), .REVISION(RV), .EXT_FLAG(1'b0)) i_dut2 (
    .I_MCLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(), .O_BRESP(bresp2),
    .O_BVALID(bvalid2), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(), .O_RDATA(rdata2), .O_RRESP(rresp2), .O_RVALID(rvalid2),
    .I_RREADY(rready));

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic timeout(input int n);
    if (n >= 50) begin
      fail_count++;
      final_report();
    end
  endtask : timeout

  // late: rready comes up only after the answer is seen, so the answer must wait
  task automatic rd(input logic [31:0] a, input logic late);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= ~late;
    do begin @(posedge clk); n++; end while (arready !== 1'b1 && n < 50);
    arvalid <= 1'b0;
    do begin @(posedge clk); n++; end while (rvalid !== 1'b1 && n < 50);
    if (late) begin
      rready <= 1'b1;
      @(posedge clk);
      n++;
    end
    d = rdata;
    d2 = rdata2;
    r = rresp;
    r2 = rresp2;
    v2 = rvalid2;
    rready <= 1'b0;
    @(posedge clk);
    timeout(n);
  endtask : rd

  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [3:0] s);
    int n;
    logic aw;
    logic w;
    n = 0;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w) && n < 50) begin
      @(posedge clk);
      n++;
      if (!aw && awready === 1'b1) begin aw = 1'b1; awvalid <= 1'b0; end
      if (!w && wready === 1'b1) begin w = 1'b1; wvalid <= 1'b0; end
    end
    do begin @(posedge clk); n++; end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    r2 = bresp2;
    v2 = bvalid2;
    bready <= 1'b0;
    @(posedge clk);
    timeout(n);
  endtask : wr

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
    wstrb = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      // writes land mid-table so the rereads show nothing moved
      if (i == 3) begin
        wr(32'h0, 32'h0, 4'hF);
        chk({30'h0, r}, {30'h0, DIR_RESP_OKAY});
        chk({30'h0, r2}, {30'h0, DIR_RESP_OKAY});
        chk({31'h0, v2}, 32'h1);
        wr(32'h4, 32'hFFFF_FFFF, 4'h3);
        chk({30'h0, r}, {30'h0, DIR_RESP_OKAY});
        chk({30'h0, r2}, {30'h0, DIR_RESP_OKAY});
      end
      rd(adr[i], (i % 2) == 1);
      chk(d, e1[i]);
      chk(d2, e2[i]);
      chk({30'h0, r}, {30'h0, (i == 3) ? DIR_RESP_DECERR : DIR_RESP_OKAY});
      chk({30'h0, r2}, {30'h0, (i == 3) ? DIR_RESP_DECERR : DIR_RESP_OKAY});
      chk({31'h0, v2}, 32'h1);
    end
    final_report();
  end
endmodule : dir_top_tb
`default_nettype wire
